// ### verilog/uart_baud_frame_transmitter.v
// Purpose: Baud generator and frame transmitter with AHB-Lite registers.
// Assumes: Single clock; bus master on the same clock.
// Notes: Receiver datapath is outside this block; its flags read idle.
`timescale 1ns/1ps
`include "uart_tx_defines.vh"

module uart_baud_frame_transmitter (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Serial pins
    output reg tx_out,
    output reg tx_oe,
    output reg rx_pin_en
);

    // ------------------------------------------------------------
    // Transmit states
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READY = 3'h1;
    localparam [2:0] ST_START = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_STOP = 3'h4;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [7:0] control_one_q; // Format and global enable
    reg [7:0] control_two_q; // Enables and speed select
    reg [7:0] baud_divisor_q; // Timer reload value
    reg [7:0] tx_holding_q; // Word waiting for the shifter
    reg hold_full_q; // Holding register occupied
    reg tx_idle_flag_q; // No frame in progress
    reg rx_idle_flag_q; // Receiver idle, kept for disable
    reg [8:0] tx_shift_q; // Not mapped to any address
    reg [2:0] state_q; // Transmit state
    reg [3:0] bit_cnt_q; // Bits sent in the current phase
    reg [7:0] div_cnt_q; // Baud timer count
    reg [5:0] pre_cnt_q; // Oversample prescaler
    reg wr_pend_q; // Write data phase pending
    reg [7:0] wr_addr_q; // Address of pending write

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    wire global_en = control_one_q[`B1_GLOBAL_EN];
    wire word_nine = control_one_q[`B1_WORD_LEN];
    wire par_en = control_one_q[`B1_PAR_EN];
    wire par_odd = control_one_q[`B1_PAR_TYPE];
    wire two_stop_count_select = control_one_q[`B1_STOP_COUNT_SELECT];
    wire tx_en = control_two_q[`B2_TX_EN];
    wire speed_high = control_two_q[`B2_SPEED];
    wire tx_buffer_empty_flag = ~hold_full_q;
    wire shifter_busy = (state_q != ST_IDLE);

    // Bus address phase accepted this edge
    wire addr_ok = hsel & hready & htrans[1];

    // Write strobes seen in the data phase
    wire wr_one = wr_pend_q & (wr_addr_q == `OFS_CONTROL_ONE);
    wire wr_two = wr_pend_q & (wr_addr_q == `OFS_CONTROL_TWO);
    wire wr_div = wr_pend_q & (wr_addr_q == `OFS_BAUD_DIVISOR);
    // Data writes are inhibited while the holding register is full
    wire wr_data = wr_pend_q & (wr_addr_q == `OFS_TX_DATA) & tx_buffer_empty_flag;

    // Next control values after a register write
    wire [7:0] one_d = wr_one ? hwdata[7:0] : control_one_q;
    wire [7:0] two_w = wr_two ? hwdata[7:0] : control_two_q;
    wire global_off = ~one_d[`B1_GLOBAL_EN];
    // Enables read as cleared whenever the port is globally off
    wire [7:0] two_d = global_off ? (two_w & 8'h3F) : two_w;
    // Abort when transmit enable or global enable goes away
    wire tx_abort = global_off | (tx_en & ~two_d[`B2_TX_EN]);

    // ------------------------------------------------------------
    // Baud timer: tick every N+1 clocks, bit every 16 or 64 ticks
    // ------------------------------------------------------------
    wire baud_tick = (div_cnt_q == 8'h00);
    wire [5:0] pre_limit = speed_high ? `PRESCALE_HIGH : `PRESCALE_LOW;
    wire bit_tick = baud_tick & (pre_cnt_q == pre_limit);
    // Data bits per frame from the word length select
    wire [3:0] nbits = word_nine ? 4'h9 : 4'h8;
    wire [3:0] nstops = two_stop_count_select ? 4'h2 : 4'h1;

    // Build the word that the shifter will send
    function [8:0] frame_word;
        input [7:0] data;
        input ninth;
        input nine;
        input pen;
        input odd;
        reg [8:0] w;
        begin
            w = {ninth, data};
            if (pen) begin
                // Parity over the data bits only, placed on top
                if (nine) begin
                    w[8] = (^data) ^ odd;
                end else begin
                    w[7] = (^data[6:0]) ^ odd;
                end
            end
            // Without parity the top bit is the address mark
            frame_word = w;
        end
    endfunction

    wire [8:0] new_word = frame_word(tx_holding_q, control_one_q[`B1_NINTH],
        word_nine, par_en, par_odd);
    wire [8:0] direct_word = frame_word(hwdata[7:0], control_one_q[`B1_NINTH],
        word_nine, par_en, par_odd);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    function [7:0] read_reg;
        input [7:0] addr;
        input [7:0] c1;
        input [7:0] c2;
        input [7:0] dv;
        input [7:0] st;
        begin
            case (addr)
                `OFS_CONTROL_ONE: begin
                    // Ninth transmit bit is write only
                    read_reg = c1 & 8'hFE;
                end
                `OFS_CONTROL_TWO: begin
                    read_reg = c2;
                end
                `OFS_BAUD_DIVISOR: begin
                    read_reg = dv;
                end
                `OFS_STATUS: begin
                    read_reg = st;
                end
                default: begin
                    // Data port and unmapped space read zero
                    read_reg = 8'h00;
                end
            endcase
        end
    endfunction

    wire [7:0] status_word = {5'h00, rx_idle_flag_q, tx_idle_flag_q,
        tx_buffer_empty_flag};

    // ------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            // Ready rises one edge after reset release
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_q <= {haddr[7:2], 2'b00};
            end
            // Read data is latched in the address phase
            if (addr_ok & ~hwrite) begin
                hrdata <= {24'h000000, read_reg({haddr[7:2], 2'b00},
                    control_one_q, control_two_q, baud_divisor_q, status_word)};
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_one_q <= `RST_CONTROL_ONE;
            control_two_q <= `RST_CONTROL_TWO;
            baud_divisor_q <= `RST_BAUD_DIVISOR;
        end else begin
            // Global off also drops the break request
            control_one_q <= global_off ? (one_d & 8'hFB) : one_d;
            control_two_q <= two_d;
            if (wr_div) begin
                baud_divisor_q <= hwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Baud timer, free running from the divisor
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= 8'h00;
            pre_cnt_q <= 6'h00;
        end else begin
            if (baud_tick) begin
                div_cnt_q <= baud_divisor_q;
                if (bit_tick) begin
                    pre_cnt_q <= 6'h00;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 6'h01;
                end
            end else begin
                div_cnt_q <= div_cnt_q - 8'h01;
            end
            // A speed change could leave the prescaler past its limit
            if (pre_cnt_q > pre_limit) begin
                pre_cnt_q <= 6'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter: holding register, shifter and frame sequencer
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_holding_q <= 8'h00;
            hold_full_q <= 1'b0;
            tx_idle_flag_q <= 1'b1;
            rx_idle_flag_q <= 1'b1;
            tx_shift_q <= 9'h000;
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            tx_out <= 1'b1;
            tx_oe <= 1'b0;
            rx_pin_en <= 1'b0;
        end else begin
            // Pins are driven only with both enables set
            tx_oe <= ~global_off & two_d[`B2_TX_EN];
            rx_pin_en <= ~global_off & two_d[`B2_RX_EN];
            rx_idle_flag_q <= 1'b1;
            if (tx_abort) begin
                // Drop everything; configuration is left intact
                hold_full_q <= 1'b0;
                tx_idle_flag_q <= 1'b1;
                state_q <= ST_IDLE;
                bit_cnt_q <= 4'h0;
                tx_out <= 1'b1;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        tx_out <= 1'b1;
                        if (hold_full_q) begin
                            // A word that landed as the last stop ended must not be stranded
                            tx_shift_q <= new_word;
                            hold_full_q <= 1'b0;
                            state_q <= ST_READY;
                        end else if (wr_data) begin
                            // Empty shifter takes the word at once
                            tx_shift_q <= direct_word;
                            tx_idle_flag_q <= 1'b0;
                            state_q <= ST_READY;
                        end
                    end
                    ST_READY: begin
                        // Wait for the enable and a bit boundary
                        if (tx_en & bit_tick) begin
                            tx_out <= 1'b0;
                            state_q <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (bit_tick) begin
                            tx_out <= tx_shift_q[0];
                            tx_shift_q <= {1'b0, tx_shift_q[8:1]};
                            bit_cnt_q <= 4'h1;
                            state_q <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (bit_tick) begin
                            if (bit_cnt_q == nbits) begin
                                tx_out <= 1'b1;
                                bit_cnt_q <= 4'h1;
                                state_q <= ST_STOP;
                            end else begin
                                tx_out <= tx_shift_q[0];
                                tx_shift_q <= {1'b0, tx_shift_q[8:1]};
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (bit_tick) begin
                            if (bit_cnt_q == nstops) begin
                                // Last stop bit done: reload if a word waits
                                if (hold_full_q) begin
                                    tx_shift_q <= new_word;
                                    hold_full_q <= 1'b0;
                                    tx_out <= 1'b0;
                                    state_q <= ST_START;
                                end else begin
                                    tx_idle_flag_q <= 1'b1;
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
                // A write during a frame waits in the holding register
                if (wr_data & shifter_busy) begin
                    tx_holding_q <= hwdata[7:0];
                    hold_full_q <= 1'b1;
                    tx_idle_flag_q <= 1'b0;
                end
            end
        end
    end

endmodule

// ### verilog/uart_tx_defines.vh
// Purpose: Constants for the baud generator and frame transmitter.
// Assumes: AHB-Lite register window, one word per register.
// Notes: Included by bare name; definitions only.
// Behaviour
// - Bit rate is clock over 64(N+1) or 16(N+1)
// - Free running 8-bit timer, divisor 0 to 255
// - Divisor register eight bits, read and write
// - Start, eight or nine bits, one or two stop_count_select
// - Reset gives eight bits, no parity, one stop
// - Words travel least significant bit first
// - Shared frame format and shared bit rate
// - All enables set: pins active, line idles high
// - Global clear floats pins, empties buffers
// - Global clear resets enables and status flags
// - Global clear stop_count_select transfers, configuration kept
// - Parity or address takes top word bit
// - Top word bit marks address characters
// - Ninth bit comes from dedicated control bit
// - Shifter reloads only after last stop bit
// - Frame starts once word loaded, clock running
// - Idle shifter takes written word at once
// - Transmit enable clear aborts, floats output
// - Shift register has no software address
// - Speed select zero slow, one fast
// - Parity type zero even, one odd
// - Word length zero eight, one nine bits
`ifndef UART_TX_DEFINES_VH
`define UART_TX_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_BAUD_DIVISOR 8'h08
`define OFS_STATUS 8'h0C
`define OFS_TX_DATA 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define B1_GLOBAL_EN 7
`define B1_WORD_LEN 6
`define B1_PAR_EN 5
`define B1_PAR_TYPE 4
`define B1_STOP_COUNT_SELECT 3
`define B1_BREAK 2
`define B1_NINTH 0
`define B2_TX_EN 7
`define B2_RX_EN 6
`define B2_SPEED 5
`define ST_TX_EMPTY 0
`define ST_TX_IDLE 1
`define ST_RX_IDLE 2

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define RST_CONTROL_ONE 8'h00
`define RST_CONTROL_TWO 8'h00
`define RST_BAUD_DIVISOR 8'h00
`define PRESCALE_LOW 6'h3F
`define PRESCALE_HIGH 6'h0F

`endif

// ### tb/uart_baud_frame_transmitter_monitor.sv
// Purpose: Port-level checker for the baud generator and frame transmitter.
// Assumes: Registers sit on the aligned byte offsets of the design header.
// Notes: Bus helpers shadow only the global enable and the divisor.
`timescale 1ns/1ps
module uart_baud_frame_transmitter_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Bus side
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    // Serial pins
    input wire tx_out,
    input wire tx_oe,
    input wire rx_pin_en
);
    // ----
    // Helper logic
    // ----
    logic wv_q; // Write in data phase
    logic [7:0] wa_q; // Its address
    logic rdv_q; // Divisor read in data phase
    logic g_q; // Global enable as last written
    logic [7:0] dv_q; // Divisor as last written
    logic prev_q; // Line one cycle back
    logic [4:0] run_q; // Cycles since the line last moved, saturating
    // Track writes and line run length
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wv_q <= 1'b0;
            wa_q <= 8'h00;
            rdv_q <= 1'b0;
            g_q <= 1'b0;
            dv_q <= 8'h00;
            prev_q <= 1'b1;
            run_q <= 5'h1F;
        end else begin
            wv_q <= hsel & hready & htrans[1] & hwrite;
            wa_q <= haddr;
            rdv_q <= hsel & hready & htrans[1] & !hwrite & (haddr == 8'h08);
            if (wv_q && wa_q == 8'h00) g_q <= hwdata[7];
            if (wv_q && wa_q == 8'h08) dv_q <= hwdata[7:0];
            prev_q <= tx_out;
            run_q <= (tx_out != prev_q) ? 5'h00 : ((run_q == 5'h1F) ? run_q : run_q + 5'h01);
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_oe_idle; !tx_oe |-> tx_out; endproperty
    property p_bit_len; (tx_oe && $past(tx_oe) && tx_out != prev_q) |-> run_q >= 5'h0E; endproperty
    property p_glob_off; (wv_q && wa_q == 8'h00 && !hwdata[7]) |-> ##[1:2] (!tx_oe && !rx_pin_en); endproperty
    property p_tx_off; (wv_q && wa_q == 8'h04 && !hwdata[7]) |-> ##[1:2] (!tx_oe && tx_out); endproperty
    property p_enable; (wv_q && wa_q == 8'h04 && hwdata[7] && hwdata[6] && g_q) |-> ##[1:2] (tx_oe && rx_pin_en);
    endproperty
    property p_start; (wv_q && wa_q == 8'h10 && tx_oe && g_q) |-> ##[1:1000] (!tx_out || !tx_oe); endproperty
    property p_div_rd; rdv_q |-> hrdata == {24'h000000, $past(dv_q)}; endproperty
    property p_float_off; (!g_q && !$past(g_q) && !$past(g_q, 2)) |-> (!tx_oe && !rx_pin_en); endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("Line not high while released");
    a_bit_len: assert property (p_bit_len)
        else $error("Line level shorter than the shortest bit");
    a_glob_off: assert property (p_glob_off)
        else $error("Pins still driven after global clear");
    a_tx_off: assert property (p_tx_off)
        else $error("Output still driven after transmit clear");
    a_enable: assert property (p_enable)
        else $error("Pins not taken after enables set");
    a_start: assert property (p_start)
        else $error("No start bit after data write");
    a_div_rd: assert property (p_div_rd)
        else $error("Divisor read back wrong");
    a_float_off: assert property (p_float_off)
        else $error("Pins driven while globally off");
    c_frame: cover property ($fell(tx_out) && tx_oe);
    c_abort: cover property ($fell(tx_oe));
    c_div: cover property (rdv_q);
endmodule

// ### tb/uart_serial_peer.sv
// Purpose: Remote receiver that decodes frames from the serial line.
// Assumes: Line is pulled high when the pin floats.
// Notes: Samples each bit at its centre; bit 15 of a word marks bad framing.
`timescale 1ns/1ps
module uart_serial_peer (
    // Clock and line
    input wire sys_clk,
    input wire line,
    // Frame shape
    input wire [15:0] bit_len,
    input wire [3:0] nbits,
    input wire [1:0] nstop
);
    int got[$]; // Decoded words in arrival order
    int w; // Word being built
    logic ok; // Framing still good
    // Frame capture
    initial begin
        forever begin
            @(negedge line);
            repeat (bit_len / 2) @(posedge sys_clk);
            ok = (line === 1'b0);
            w = 0;
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_len) @(posedge sys_clk);
                w = w | (int'(line) << i);
            end
            for (int i = 0; i < nstop; i++) begin
                repeat (bit_len) @(posedge sys_clk);
                ok = ok & (line === 1'b1);
            end
            got.push_back(w | (ok ? 0 : 32'h8000));
        end
    end
endmodule

// ### tb/uart_baud_frame_transmitter_tb.sv
// Purpose: Self-checking bench for the baud generator and frame transmitter.
// Assumes: Zero-wait bus slave; bus master on the same clock.
// Notes: Expected frames are rebuilt from data and control values.
`timescale 1ns/1ps
module uart_baud_frame_transmitter_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire tx_out;
    wire tx_oe;
    wire rx_pin_en;
    wire line = tx_oe ? tx_out : 1'b1; // Pull-up on the floating pin
    logic [15:0] bit_len = 16'h10;
    logic [3:0] nbits = 4'h8;
    logic [1:0] nstop = 2'h1;
    int err_count = 0;
    int checked = 0;
    int polls = 0;
    logic [7:0] seed = 8'h1C;
    logic [31:0] r;
    logic [7:0] d1;
    logic [7:0] d2;
    // Per entry: divisor [23:16], speed [8], control one [7:0]
    logic [31:0] cfg [7] = '{32'h0180, 32'h101A0, 32'h201B8, 32'h01C1, 32'h101E8, 32'h01F0, 32'h0088};
    uart_baud_frame_transmitter dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_out(tx_out), .tx_oe(tx_oe),
        .rx_pin_en(rx_pin_en));
    uart_serial_peer peer (.sys_clk(sys_clk), .line(line), .bit_len(bit_len), .nbits(nbits), .nstop(nstop));
    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic give_up();
        err_count++;
        test_done();
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    // Frame word: ninth bit in 9-bit mode, parity over the lower bits
    function automatic int exp_w(input logic [7:0] d, input logic [31:0] c);
        int w;
        int top;
        w = {c[6] & c[0], d};
        top = c[6] ? 8 : 7;
        if (c[5]) begin
            w[top] = 1'b0;
            w[top] = (^w) ^ c[4];
        end
        return w;
    endfunction
    // Bus master; slave answer bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) give_up();
            @(posedge sys_clk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", r, e);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic rx_check(input int e);
        int n;
        n = 0;
        while (peer.got.size() == 0) begin
            n++;
            if (n > 20000) give_up();
            @(posedge sys_clk);
        end
        chk("frame", peer.got.pop_front(), e);
    endtask
    task automatic setup(input logic [31:0] c);
        bus(1'b1, 8'h08, {24'h0, c[23:16]});
        bus(1'b1, 8'h00, {24'h0, c[7:0]});
        bus(1'b1, 8'h04, {24'h0, 2'h3, c[8], 5'h0});
        bit_len = (16'(c[23:16]) + 16'h1) * (c[8] ? 16'h10 : 16'h40);
        nbits = c[6] ? 4'h9 : 4'h8;
        nstop = c[3] ? 2'h2 : 2'h1;
    endtask
    task automatic flush();
        repeat (800) @(posedge sys_clk);
        peer.got.delete();
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h0C, 32'h7);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h0);
        d1 = rnd();
        bus(1'b1, 8'h08, {24'h0, d1});
        rd_chk(8'h08, {24'h0, d1});
        bus(1'b1, 8'h08, 32'hFF);
        rd_chk(8'h08, 32'hFF);
        foreach (cfg[i]) begin
            setup(cfg[i]);
            d1 = rnd();
            d2 = rnd();
            bus(1'b1, 8'h10, {24'h0, d1});
            bus(1'b1, 8'h10, {24'h0, d2});
            rd_chk(8'h0C, 32'h4);
            rx_check(exp_w(d1, cfg[i]));
            rx_check(exp_w(d2, cfg[i]));
            r = 32'h0;
            polls = 0;
            while (r[1] !== 1'b1) begin
                polls++;
                if (polls > 200) give_up();
                bus(1'b0, 8'h0C, 32'h0);
            end
            chk("status", r, 32'h7);
        end
        setup(cfg[0]);
        bus(1'b1, 8'h10, {24'h0, rnd()});
        repeat (40) @(posedge sys_clk);
        bus(1'b1, 8'h04, 32'h20);
        repeat (2) @(posedge sys_clk);
        chk("tx_oe", {31'h0, tx_oe}, 32'h0);
        rd_chk(8'h0C, 32'h7);
        flush();
        setup(cfg[2]);
        bus(1'b1, 8'h10, {24'h0, rnd()});
        repeat (60) @(posedge sys_clk);
        bus(1'b1, 8'h00, 32'h38);
        repeat (2) @(posedge sys_clk);
        chk("pins", {30'h0, tx_oe, rx_pin_en}, 32'h0);
        rd_chk(8'h04, 32'h20);
        rd_chk(8'h00, 32'h38);
        rd_chk(8'h08, 32'h2);
        rd_chk(8'h0C, 32'h7);
        flush();
        bus(1'b1, 8'h00, 32'hB8);
        bus(1'b1, 8'h04, 32'hE0);
        d1 = rnd();
        bus(1'b1, 8'h10, {24'h0, d1});
        rx_check(exp_w(d1, cfg[2]));
        bus(1'b1, 8'h04, 32'h20);
        d1 = rnd();
        bus(1'b1, 8'h10, {24'h0, d1});
        bus(1'b1, 8'h04, 32'hE0);
        rx_check(exp_w(d1, cfg[2]));
        test_done();
    end
endmodule
bind uart_baud_frame_transmitter uart_baud_frame_transmitter_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .tx_out(tx_out), .tx_oe(tx_oe), .rx_pin_en(rx_pin_en));
